// file: shared/umd_char_if.sv
// Byte stream between the buffer scanner and the character filter
`timescale 1ns/1ps
`default_nettype none

interface umd_char_if;
    logic                  in_valid;   // Byte offered
    logic [7:0]            in_code;    // Raw buffer byte
    logic [5:0]            in_pos;     // Line in [5:4], column in [3:0]
    logic                  in_first;   // First byte of a frame
    logic                  out_valid;  // Cell ready
    logic [7:0]            out_code;   // Code to render
    umd_pkg::char_kind_t   out_kind;   // Rendering kind
    logic [5:0]            out_pos;    // Cell position
    logic                  out_first;  // First cell of a frame

    modport feeder (output in_valid, in_code, in_pos, in_first,
                    input  out_valid, out_code, out_kind, out_pos, out_first);
    modport filter (input  in_valid, in_code, in_pos, in_first,
                    output out_valid, out_code, out_kind, out_pos, out_first);
endinterface

`default_nettype wire

// file: shared/umd_defines.svh
// Constants for the message text display controller
`ifndef UMD_DEFINES_SVH
`define UMD_DEFINES_SVH

// Buffer word offsets above the word base
`define UMD_TEXT_FIRST     16'h0009
`define UMD_TEXT_LAST      16'h0028
// Screen geometry
`define UMD_LAST_COL       4'hF
`define UMD_LAST_BYTE      6'h3F
// Accepted single-byte code ranges
`define UMD_SB1_LO         8'h20
`define UMD_SB1_HI         8'h7D
`define UMD_SB2_LO         8'hA1
`define UMD_SB2_HI         8'hDF
// Two-byte lead byte ranges
`define UMD_LEAD1_LO       8'h81
`define UMD_LEAD1_HI       8'h9F
`define UMD_LEAD2_LO       8'hE0
`define UMD_LEAD2_HI       8'hEF
// Blank character
`define UMD_SPACE          8'h20
// Refresh timing
`define UMD_CLK_HZ         20000000
`define UMD_REFRESH_MS     100
`define UMD_REFRESH_CYCLES ((`UMD_CLK_HZ / 1000) * `UMD_REFRESH_MS)

`endif

// file: shared/umd_pkg.sv
// Types for the message text display controller
package umd_pkg;

    // Which screen the display shows
    typedef enum logic [1:0]
    {
        SCR_MAIN    = 2'h0,
        SCR_MESSAGE = 2'h1,
        SCR_MENU    = 2'h3,
        SCR_USERDEV = 2'h2
    } screen_t;

    // Buffer scan sequencer
    typedef enum logic [2:0]
    {
        SCAN_IDLE  = 3'h0,
        SCAN_FETCH = 3'h1,
        SCAN_WAIT  = 3'h3,
        SCAN_LATCH = 3'h2,
        SCAN_EMIT  = 3'h6
    } scan_t;

    // How a character cell is rendered
    typedef enum logic [1:0]
    {
        KIND_SINGLE = 2'h0,
        KIND_LEAD   = 2'h1,
        KIND_TRAIL  = 2'h2,
        KIND_BLANK  = 2'h3
    } char_kind_t;

endpackage

// file: src/umd_char_filter.sv
// Character code check and two-byte pairing
`timescale 1ns/1ps
`default_nettype none
`include "umd_defines.svh"

module umd_char_filter
(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // Byte stream
    umd_char_if.filter      chr
);

    logic                 pair;        // Previous byte was a lead, this is its trail
    logic                 pend;        // Lead cut at line end, next byte is blanked
    logic                 next_pair;
    logic                 next_pend;
    logic                 next_valid;
    logic [7:0]           next_code;
    umd_pkg::char_kind_t  next_kind;
    logic                 is_lead;
    logic                 is_single;
    logic                 pair_in;
    logic                 pend_in;

    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    // Ranges of accepted codes
    always_comb
    begin
        is_single = ((chr.in_code >= `UMD_SB1_LO) && (chr.in_code <= `UMD_SB1_HI)) ||
                    ((chr.in_code >= `UMD_SB2_LO) && (chr.in_code <= `UMD_SB2_HI));
        is_lead   = ((chr.in_code >= `UMD_LEAD1_LO) && (chr.in_code <= `UMD_LEAD1_HI)) ||
                    ((chr.in_code >= `UMD_LEAD2_LO) && (chr.in_code <= `UMD_LEAD2_HI));
        // A new frame forgets any pairing left over
        pair_in   = pair && !chr.in_first;
        pend_in   = pend && !chr.in_first;
    end

    // Next cell and pairing state
    always_comb
    begin
        next_pair  = pair;
        next_pend  = pend;
        next_valid = chr.in_valid;
        next_code  = chr.out_code;
        next_kind  = chr.out_kind;
        if (chr.in_valid)
        begin
            next_pair = 1'b0;
            next_pend = 1'b0;
            if (pair_in)
            begin
                // Second half of a two-byte character
                next_code = chr.in_code;
                next_kind = umd_pkg::KIND_TRAIL;
            end
            else if (pend_in)
            begin
                // Tail of a character cut by the line end
                next_code = `UMD_SPACE;
                next_kind = umd_pkg::KIND_BLANK;
            end
            else if (is_lead && (chr.in_pos[3:0] == `UMD_LAST_COL))
            begin
                // Lead in the last column would straddle lines
                next_code = `UMD_SPACE;
                next_kind = umd_pkg::KIND_BLANK;
                next_pend = 1'b1;
            end
            else if (is_lead)
            begin
                // First half of a two-byte character
                next_code = chr.in_code;
                next_kind = umd_pkg::KIND_LEAD;
                next_pair = 1'b1;
            end
            else if (is_single)
            begin
                next_code = chr.in_code;
                next_kind = umd_pkg::KIND_SINGLE;
            end
            else
            begin
                // Codes outside the accepted sets show blank
                next_code = `UMD_SPACE;
                next_kind = umd_pkg::KIND_BLANK;
            end
        end
    end

    // Registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pair          <= 1'b0;
            pend          <= 1'b0;
            chr.out_valid <= 1'b0;
            chr.out_code  <= 8'h00;
            chr.out_kind  <= umd_pkg::KIND_BLANK;
            chr.out_pos   <= 6'h00;
            chr.out_first <= 1'b0;
        end
        else
        begin
            pair          <= next_pair;
            pend          <= next_pend;
            chr.out_valid <= next_valid;
            chr.out_code  <= next_code;
            chr.out_kind  <= next_kind;
            chr.out_pos   <= chr.in_pos;
            chr.out_first <= chr.in_first;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SINGLE_PASSES: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (chr.in_valid && !pair_in && !pend_in && is_single)
        |=> (chr.out_code == $past(chr.in_code)) && (chr.out_kind == umd_pkg::KIND_SINGLE))
        else $error("accepted single-byte code not passed");

    AST_PAIR_KEPT: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (chr.in_valid && !pair_in && !pend_in && is_lead && (chr.in_pos[3:0] != `UMD_LAST_COL))
        |=> (chr.out_kind == umd_pkg::KIND_LEAD)
            ##1 (!$past(chr.in_valid) || $past(chr.in_first) ||
                 (chr.out_kind == umd_pkg::KIND_TRAIL)))
        else $error("two-byte character not kept as a pair");

    AST_STRADDLE_BLANK: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (chr.in_valid && !pair_in && !pend_in && is_lead && (chr.in_pos[3:0] == `UMD_LAST_COL))
        |=> (chr.out_code == `UMD_SPACE) ##4 (!$past(chr.in_valid) || $past(chr.in_first) ||
                                            (chr.out_kind == umd_pkg::KIND_BLANK)))
        else $error("straddling character not blanked");

endmodule

`default_nettype wire

// file: src/umd_text_display.sv
// Message screen control and message buffer scanner
`timescale 1ns/1ps
`default_nettype none
`include "umd_defines.svh"

// Function
// - Text held and read only at offsets 9-40
// - Accept single bytes 20-7D and A1-DF
// - Render two-byte Shift JIS characters as pairs
// - Four lines of sixteen, eight words each
// - Low byte left, high byte right
// - Command on enters message only from main
// - Command off returns to main screen
// - Status high on user-device or message screen
// - Line-straddling two-byte character shows two spaces
module umd_text_display
#(
    parameter int unsigned REFRESH_CYCLES = `UMD_REFRESH_CYCLES  // Cycles between rescans
)
(
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    // Controller bits and word base
    input  wire logic                show_cmd_in,      // Message display command bit
    input  wire logic [15:0]         word_base_in,     // Base of the system words
    output logic                     screen_flag_out,  // Status bit
    // Operator keys, one-cycle pulses
    input  wire logic                key_ok_in,        // To the menu screen
    input  wire logic                key_back_in,      // Menu back to main
    input  wire logic                key_userdev_in,   // Menu to user-device monitor
    // Buffer word read port
    output logic                     rd_en_out,
    output logic [15:0]              rd_addr_out,
    input  wire logic [15:0]         rd_data_in,
    // Character cells to the panel
    output logic                     char_valid_out,
    output logic [7:0]               char_code_out,
    output umd_pkg::char_kind_t      char_kind_out,
    output logic [1:0]               char_line_out,
    output logic [3:0]               char_col_out,
    output logic                     frame_start_out,
    output umd_pkg::screen_t         screen_out
);

    umd_char_if              chr ();       // Scanner to filter stream

    umd_pkg::screen_t        screen;       // Screen shown
    umd_pkg::screen_t        next_screen;
    umd_pkg::scan_t          scan;         // Scanner state
    umd_pkg::scan_t          next_scan;
    logic [5:0]              byte_idx;     // Byte being scanned
    logic [5:0]              next_byte_idx;
    logic [15:0]             word_q;       // Word being emitted
    logic [15:0]             next_word_q;
    logic [15:0]             base_q;       // Base held for one frame
    logic [15:0]             next_base_q;
    logic [31:0]             refresh_cnt;  // Cycles to the next rescan
    logic [31:0]             next_refresh_cnt;
    logic                    next_rd_en;
    logic [15:0]             next_rd_addr;
    logic                    next_flag;

    // ------------------------------------------------------------
    // Screen selection
    // ------------------------------------------------------------
    // Next screen from command bit and keys
    always_comb
    begin
        next_screen = screen;
        case (screen)
            umd_pkg::SCR_MAIN:
            begin
                if (show_cmd_in)
                    next_screen = umd_pkg::SCR_MESSAGE;
                else if (key_ok_in)
                    next_screen = umd_pkg::SCR_MENU;
            end
            umd_pkg::SCR_MESSAGE:
            begin
                if (!show_cmd_in)
                    next_screen = umd_pkg::SCR_MAIN;
                else if (key_ok_in)
                    next_screen = umd_pkg::SCR_MENU;
            end
            umd_pkg::SCR_MENU:
            begin
                // Command is ignored on the menu and user-device screens
                if (key_back_in)
                    next_screen = umd_pkg::SCR_MAIN;
                else if (key_userdev_in)
                    next_screen = umd_pkg::SCR_USERDEV;
            end
            umd_pkg::SCR_USERDEV:
            begin
                if (key_back_in)
                    next_screen = umd_pkg::SCR_MENU;
            end
            default:
                next_screen = umd_pkg::SCR_MAIN;
        endcase
        next_flag = (next_screen == umd_pkg::SCR_MESSAGE) ||
                    (next_screen == umd_pkg::SCR_USERDEV);
    end

    // ------------------------------------------------------------
    // Buffer scanner
    // ------------------------------------------------------------
    // Fetch each word, then emit its low and high bytes
    always_comb
    begin
        next_scan        = scan;
        next_byte_idx    = byte_idx;
        next_word_q      = word_q;
        next_base_q      = base_q;
        next_rd_en       = 1'b0;
        next_rd_addr     = rd_addr_out;
        next_refresh_cnt = refresh_cnt;
        if (screen != umd_pkg::SCR_MESSAGE)
        begin
            // Next entry starts a scan at once
            next_scan        = umd_pkg::SCAN_IDLE;
            next_refresh_cnt = 32'h0000_0000;
        end
        else
        begin
            if (refresh_cnt != 32'h0000_0000)
                next_refresh_cnt = refresh_cnt - 32'h0000_0001;
            case (scan)
                umd_pkg::SCAN_IDLE:
                begin
                    if (refresh_cnt == 32'h0000_0000)
                    begin
                        next_scan        = umd_pkg::SCAN_FETCH;
                        next_byte_idx    = 6'h00;
                        next_base_q      = word_base_in;
                        next_refresh_cnt = 32'(REFRESH_CYCLES - 1);
                    end
                end
                umd_pkg::SCAN_FETCH:
                begin
                    next_rd_en   = 1'b1;
                    next_rd_addr = base_q + `UMD_TEXT_FIRST + {11'h000, byte_idx[5:1]};
                    next_scan    = umd_pkg::SCAN_WAIT;
                end
                umd_pkg::SCAN_WAIT:
                    next_scan = umd_pkg::SCAN_LATCH;
                umd_pkg::SCAN_LATCH:
                begin
                    next_word_q = rd_data_in;
                    next_scan   = umd_pkg::SCAN_EMIT;
                end
                umd_pkg::SCAN_EMIT:
                begin
                    next_byte_idx = byte_idx + 6'h01;
                    if (byte_idx == `UMD_LAST_BYTE)
                        next_scan = umd_pkg::SCAN_IDLE;
                    else if (byte_idx[0])
                        next_scan = umd_pkg::SCAN_FETCH;
                end
                default:
                    next_scan = umd_pkg::SCAN_IDLE;
            endcase
        end
    end

    // Byte offered to the filter, low byte on the left
    always_comb
    begin
        chr.in_valid = (scan == umd_pkg::SCAN_EMIT);
        chr.in_code  = byte_idx[0] ? word_q[15:8] : word_q[7:0];
        chr.in_pos   = byte_idx;
        chr.in_first = (byte_idx == 6'h00);
    end

    umd_char_filter u_filter
    (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .chr        (chr.filter)
    );

    // Registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            screen          <= umd_pkg::SCR_MAIN;
            scan            <= umd_pkg::SCAN_IDLE;
            byte_idx        <= 6'h00;
            word_q          <= 16'h0000;
            base_q          <= 16'h0000;
            refresh_cnt     <= 32'h0000_0000;
            rd_en_out       <= 1'b0;
            rd_addr_out     <= 16'h0000;
            screen_flag_out <= 1'b0;
            screen_out      <= umd_pkg::SCR_MAIN;
            char_valid_out  <= 1'b0;
            char_code_out   <= 8'h00;
            char_kind_out   <= umd_pkg::KIND_BLANK;
            char_line_out   <= 2'h0;
            char_col_out    <= 4'h0;
            frame_start_out <= 1'b0;
        end
        else
        begin
            screen          <= next_screen;
            scan            <= next_scan;
            byte_idx        <= next_byte_idx;
            word_q          <= next_word_q;
            base_q          <= next_base_q;
            refresh_cnt     <= next_refresh_cnt;
            rd_en_out       <= next_rd_en;
            rd_addr_out     <= next_rd_addr;
            screen_flag_out <= next_flag;
            screen_out      <= next_screen;
            char_valid_out  <= chr.out_valid;
            char_code_out   <= chr.out_code;
            char_kind_out   <= chr.out_kind;
            char_line_out   <= chr.out_pos[5:4];
            char_col_out    <= chr.out_pos[3:0];
            frame_start_out <= chr.out_valid && chr.out_first;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_READ_RANGE: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        rd_en_out |-> ((rd_addr_out - base_q) >= `UMD_TEXT_FIRST) &&
                      ((rd_addr_out - base_q) <= `UMD_TEXT_LAST))
        else $error("buffer read outside the text words");

    AST_LINE_WORDS: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (rd_en_out && (scan == umd_pkg::SCAN_WAIT) && (screen == umd_pkg::SCR_MESSAGE))
        ##1 (screen == umd_pkg::SCR_MESSAGE)
        |-> ##3 (char_valid_out && (char_line_out == $past(byte_idx[5:4], 4)) &&
             (char_col_out == {$past(byte_idx[3:1], 4), 1'b0}) && ($past(rd_addr_out, 4) ==
             $past(base_q, 4) + `UMD_TEXT_FIRST + {11'h000, char_line_out, char_col_out[3:1]})))
        else $error("word not placed at its line and column");

    AST_LOW_LEFT: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (scan == umd_pkg::SCAN_EMIT) && !byte_idx[0] && (screen == umd_pkg::SCR_MESSAGE) |->
        (chr.in_code == word_q[7:0]) ##1
        (byte_idx[0] && (chr.in_code == word_q[15:8])))
        else $error("byte order within a word wrong");

    AST_ENTER_FROM_MAIN: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (screen == umd_pkg::SCR_MAIN) && show_cmd_in |=> (screen == umd_pkg::SCR_MESSAGE))
        else $error("command did not open the message screen");

    AST_IGNORED_ELSEWHERE: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (screen != umd_pkg::SCR_MAIN) && (screen != umd_pkg::SCR_MESSAGE)
        |=> (screen != umd_pkg::SCR_MESSAGE))
        else $error("message screen opened away from main");

    AST_LEAVE_ON_OFF: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (screen == umd_pkg::SCR_MESSAGE) && !show_cmd_in |=> (screen == umd_pkg::SCR_MAIN))
        else $error("command off did not return to main");

    AST_STATUS_FLAG: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        ##1 (screen_flag_out == ((screen == umd_pkg::SCR_MESSAGE) ||
                                 (screen == umd_pkg::SCR_USERDEV))))
        else $error("status bit does not follow the screen");

    AST_RESCAN: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(screen == umd_pkg::SCR_MESSAGE) && show_cmd_in && !key_ok_in
        |=> (scan == umd_pkg::SCAN_FETCH) ##1 rd_en_out)
        else $error("message screen did not start a buffer scan");

endmodule

`default_nettype wire

// file: testbench/tb_umd_text_display.sv
// Self-checking bench for the message text display controller
`timescale 1ns/1ps
`default_nettype none

module tb_umd_text_display;
    localparam int unsigned REFRESH = 200;      // Short rescan period
    localparam logic [15:0] BASE    = 16'h0100; // Word base under test

    logic                clk_sys_in, rst_n_in, show_cmd_in;
    logic                key_ok_in, key_back_in, key_userdev_in;
    logic                screen_flag_out, rd_en_out, char_valid_out, frame_start_out;
    logic [15:0]         rd_addr_out, rd_data_in;
    logic [7:0]          char_code_out;
    umd_pkg::char_kind_t char_kind_out;
    logic [1:0]          char_line_out;
    logic [3:0]          char_col_out;
    umd_pkg::screen_t    screen_out;
    int                  mismatches, n_tests, frames, cells;
    logic [7:0]          seen_code [0:63];  // Last cell codes by position
    umd_pkg::char_kind_t seen_kind [0:63];  // Last cell kinds by position

    umd_text_display #(.REFRESH_CYCLES(REFRESH)) umd_text_display_i
    (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .show_cmd_in(show_cmd_in),
        .word_base_in(BASE), .screen_flag_out(screen_flag_out), .key_ok_in(key_ok_in),
        .key_back_in(key_back_in), .key_userdev_in(key_userdev_in), .rd_en_out(rd_en_out),
        .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in), .char_valid_out(char_valid_out),
        .char_code_out(char_code_out), .char_kind_out(char_kind_out),
        .char_line_out(char_line_out), .char_col_out(char_col_out),
        .frame_start_out(frame_start_out), .screen_out(screen_out)
    );

    umd_word_store umd_word_store_i
    (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .rd_en_in(rd_en_out),
        .rd_addr_in(rd_addr_out), .base_in(BASE), .rd_data_out(rd_data_in)
    );

    // Clock generator, 50 ns period
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // Compare one value and count it
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Print the verdict and stop
    task conclude;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Let n edges pass, then settle just after the last one
    task automatic step(int n);
        repeat (n) @(posedge clk_sys_in);
        #5;
    endtask

    // Wait for n further complete frames, bounded
    task automatic wait_frames(int n);
        int f0;
        int k;
        f0 = frames;
        k = 0;
        while (frames < f0 + n && k < 2000)
        begin
            @(posedge clk_sys_in);
            k++;
        end
        #5;
        check("frame_done", {15'h0000, frames >= f0 + n}, 16'h0001);
    endtask

    // Screen and status pair
    task automatic check_screen(umd_pkg::screen_t s, logic flag);
        check("screen", {14'h0000, screen_out}, {14'h0000, s});
        check("status_flag", {15'h0000, screen_flag_out}, {15'h0000, flag});
    endtask

    // Watch reads and collect cells
    always @(posedge clk_sys_in)
    begin
        if (rd_en_out === 1'b1)
            check("read_addr", {15'h0000, (rd_addr_out - BASE - 16'h0009) < 16'h0020}, 16'h0001);
        if (frame_start_out === 1'b1)
            check("frame_first_cell", {9'h000, char_valid_out, char_line_out, char_col_out},
                  16'h0040);
        if (char_valid_out === 1'b1)
        begin
            cells++;
            seen_code[{char_line_out, char_col_out}] = char_code_out;
            seen_kind[{char_line_out, char_col_out}] = char_kind_out;
            if ({char_line_out, char_col_out} == 6'h3F)
                frames++;
        end
    end

    // Expected rendering worked out from the buffer words
    task automatic compare_frame;
        logic [7:0]          b;
        logic                pend, blank_next, lead, col15;
        logic [7:0]          ec;
        umd_pkg::char_kind_t ek;
        pend = 1'b0;
        blank_next = 1'b0;
        for (int p = 0; p < 64; p++)
        begin
            b = p[0] ? umd_word_store_i.mem[p / 2][15:8] : umd_word_store_i.mem[p / 2][7:0];
            lead = (b >= 8'h81 && b <= 8'h9F) || (b >= 8'hE0 && b <= 8'hEF);
            col15 = (p % 16 == 15);
            if (pend)
            begin
                ec = b;
                ek = umd_pkg::KIND_TRAIL;
                pend = 1'b0;
            end
            else if (blank_next || (lead && col15) ||
                     !(lead || (b >= 8'h20 && b <= 8'h7D) || (b >= 8'hA1 && b <= 8'hDF)))
            begin
                ec = 8'h20;
                ek = umd_pkg::KIND_BLANK;
                blank_next = !blank_next && lead && col15;
            end
            else
            begin
                ec = b;
                ek = lead ? umd_pkg::KIND_LEAD : umd_pkg::KIND_SINGLE;
                pend = lead;
            end
            check("cell_code", {8'h00, seen_code[p]}, {8'h00, ec});
            check("cell_kind", {14'h0000, seen_kind[p]}, {14'h0000, ek});
        end
    endtask

    // Message entry with a mixed buffer and a straddling pair
    task automatic t_message;
        logic [7:0] b [0:63];
        for (int j = 0; j < 64; j++)
            b[j] = 8'h41 + 8'(j % 26);
        {b[0], b[1], b[2], b[3], b[4], b[5], b[6]} = {8'h20, 8'h7D, 8'h7E, 8'h1F, 8'hA1, 8'hDF, 8'hA0};
        {b[7], b[8], b[10], b[11], b[12], b[13]} = {8'h81, 8'h40, 8'hE0, 8'h9F, 8'h9F, 8'h9F};
        {b[15], b[47], b[63]} = {8'h88, 8'hEF, 8'h81};
        for (int w = 0; w < 32; w++)
            umd_word_store_i.mem[w] = {b[2 * w + 1], b[2 * w]};
        show_cmd_in = 1'b1;
        step(1);
        check_screen(umd_pkg::SCR_MESSAGE, 1'b1);
        wait_frames(1);
        compare_frame();
        $display("test message done");
    endtask

    // Buffer update shows up on a later refresh
    task automatic t_refresh;
        umd_word_store_i.mem[0] = 16'h8242;
        umd_word_store_i.mem[31] = 16'h9FE1;
        wait_frames(2);
        compare_frame();
        $display("test refresh done");
    endtask

    // Command off returns to main and stops cells
    task automatic t_leave;
        int c0;
        show_cmd_in = 1'b0;
        step(1);
        check_screen(umd_pkg::SCR_MAIN, 1'b0);
        c0 = cells;
        step(300);
        check("cells_after_leave", 16'(cells - c0), 16'h0000);
        $display("test leave done");
    endtask

    // Command ignored on menu and user-device screens; user-device screen sets status
    task automatic t_refused;
        key_ok_in = 1'b1;
        step(1);
        key_ok_in = 1'b0;
        check_screen(umd_pkg::SCR_MENU, 1'b0);
        show_cmd_in = 1'b1;
        step(4);
        check_screen(umd_pkg::SCR_MENU, 1'b0);
        key_userdev_in = 1'b1;
        step(1);
        key_userdev_in = 1'b0;
        check_screen(umd_pkg::SCR_USERDEV, 1'b1);
        key_back_in = 1'b1;
        step(1);
        check_screen(umd_pkg::SCR_MENU, 1'b0);
        step(1);
        key_back_in = 1'b0;
        check_screen(umd_pkg::SCR_MAIN, 1'b0);
        step(1);
        check_screen(umd_pkg::SCR_MESSAGE, 1'b1);
        show_cmd_in = 1'b0;
        step(1);
        $display("test refused done");
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (6000) @(posedge clk_sys_in);
        mismatches++;
        conclude();
    end

    // Main sequence
    initial
    begin
        {rst_n_in, show_cmd_in, key_ok_in, key_back_in, key_userdev_in} = 5'h00;
        {mismatches, n_tests, frames, cells} = {32'd0, 32'd0, 32'd0, 32'd0};
        repeat (6) @(posedge clk_sys_in);
        #5;
        rst_n_in = 1'b1;
        check_screen(umd_pkg::SCR_MAIN, 1'b0);
        t_message();
        t_refresh();
        t_leave();
        t_refused();
        conclude();
    end
endmodule

`default_nettype wire

// file: testbench/umd_word_store.sv
// Controller word store answering the display's buffer reads
`timescale 1ns/1ps
`default_nettype none

module umd_word_store
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // Read port from the display
    input  wire logic        rd_en_in,
    input  wire logic [15:0] rd_addr_in,
    input  wire logic [15:0] base_in,
    output logic      [15:0] rd_data_out
);
    logic [15:0] mem [0:31];  // Message words, offsets 9 to 40
    logic [15:0] idx;         // Request offset inside the buffer

    assign idx = rd_addr_in - base_in - 16'h0009;

    // Answer one cycle after a request; otherwise scramble so stale data never passes
    always @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rd_data_out <= 16'h0000;
        else if (rd_en_in && idx < 16'h0020)
            rd_data_out <= mem[idx[4:0]];
        else
            rd_data_out <= ~rd_data_out;
    end
endmodule

`default_nettype wire
